// [common/bcv_pkg.sv]
package bcv_pkg;

	// ********************************************************************
	// Bus and register geometry
	// ********************************************************************
	localparam int unsigned ADDR_W   = 8;
	localparam int unsigned DATA_W   = 32;
	localparam int unsigned NUM_CHAN = 2;

	// Byte addresses of the register words
	localparam logic [7:0] OFF_DIVISOR_A  = 8'h00;
	localparam logic [7:0] OFF_CONTROL_A  = 8'h04;
	localparam logic [7:0] OFF_DIVISOR_B  = 8'h08;
	localparam logic [7:0] OFF_CONTROL_B  = 8'h0C;
	localparam logic [7:0] OFF_VECTOR     = 8'h10;
	localparam logic [7:0] OFF_INT_CONFIG = 8'h14;
	localparam logic [7:0] OFF_GEN_STAT_A = 8'h18;
	localparam logic [7:0] OFF_GEN_STAT_B = 8'h1C;

	// ********************************************************************
	// Field positions
	// ********************************************************************
	localparam int unsigned CTL_GEN_ENABLE = 0;
	localparam int unsigned CTL_DIV64      = 1;
	localparam int unsigned CTL_TX_DRIVE   = 2;
	localparam int unsigned CTL_RX_DRIVE   = 3;
	localparam int unsigned CTL_USED_W     = 4;
	// Interrupt config: status-modifies-vector per channel, loop per channel
	localparam int unsigned CFG_SAV_A      = 0;
	localparam int unsigned CFG_SAV_B      = 1;
	localparam int unsigned CFG_LOOP_A     = 2;
	localparam int unsigned CFG_LOOP_B     = 3;
	localparam int unsigned CFG_USED_W     = 4;
	// Generator status: down counter in [7:0], output clock level in [8]
	localparam int unsigned STAT_CLK_BIT   = 8;

	// ********************************************************************
	// Reset values
	// ********************************************************************
	localparam logic [7:0] RST_DIVISOR = 8'h00;
	localparam logic [3:0] RST_CONTROL = 4'h0;
	localparam logic [7:0] RST_VECTOR  = 8'h0F;
	localparam logic [3:0] RST_CONFIG  = 4'h0;
	localparam logic [7:0] RST_COUNTER = 8'h00;

	// ********************************************************************
	// Generator timing and vector codes
	// ********************************************************************
	// Prescale per half output period: 2*2 = 4 and 2*32 = 64 clocks minimum
	localparam int unsigned MIN_RATIO_DIV4  = 4;
	localparam int unsigned MIN_RATIO_DIV64 = 64;
	localparam logic [5:0]  HALF_DIV4       = 6'(MIN_RATIO_DIV4 / 2 - 1);
	localparam logic [5:0]  HALF_DIV64      = 6'(MIN_RATIO_DIV64 / 2 - 1);
	localparam logic [7:0]  TERMINAL_COUNT  = 8'h01;
	localparam logic [2:0]  NO_PENDING_CODE = 3'h3;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [design/bcv_baud_gen.sv]
`timescale 1ns/1ps

module bcv_baud_gen (
	input  wire logic       clk_in,
	input  wire logic       srst_in,
	input  wire logic       ce_in,
	input  wire logic       enable_in,
	input  wire logic       div64_in,
	input  wire logic [7:0] divisor_in,
	input  wire logic       load_in,
	output logic            brg_clk_out,
	output logic [7:0]      count_out
);

	logic [5:0] presc_ff;
	logic [7:0] count_ff;
	logic       clk_ff;
	logic       tick;
	logic       terminal;

	assign tick     = enable_in && (presc_ff == (div64_in ? bcv_pkg::HALF_DIV64
		: bcv_pkg::HALF_DIV4));
	assign terminal = tick && (count_ff == bcv_pkg::TERMINAL_COUNT);

	// ********************************************************************
	// Prescaler
	// ********************************************************************
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			presc_ff <= '0;
		end else if (ce_in) begin
			if (load_in && !enable_in) begin
				presc_ff <= '0;
			end else if (tick) begin
				presc_ff <= '0;
			end else if (enable_in) begin
				presc_ff <= presc_ff + 6'h01;
			end
		end
	end

	// ********************************************************************
	// Down counter; a count of zero wraps so a zero divisor means 256
	// ********************************************************************
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			count_ff <= bcv_pkg::RST_COUNTER;
		end else if (ce_in) begin
			if (load_in && !enable_in) begin
				count_ff <= divisor_in;
			end else if (terminal) begin
				count_ff <= divisor_in;
			end else if (tick) begin
				count_ff <= count_ff - 8'h01;
			end
			// Disabled: no tick, counter keeps its value
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			clk_ff <= 1'b0;
		end else if (ce_in && terminal) begin
			clk_ff <= ~clk_ff;
		end
	end

	assign brg_clk_out = clk_ff;
	assign count_out   = count_ff;

endmodule // bcv_baud_gen

// [design/bcv_clock_vector.sv]
`timescale 1ns/1ps

// Behaviour
// - Bits 7..4 of the generator control register always read back as zero.
// - Control bit 3 set drives the receive clock pin from the generator, else it is an input.
// - The receiver clock is the receive pin signal, or the transmit clock in loop mode.
// - Control bit 2 set drives the transmit clock pin from the generator; tx uses the pin.
// - Control bit 1 picks a minimum of 64 or 4 input clocks per output clock.
// - That minimum ratio is produced with a divisor of one.
// - Setting enable resumes counting from the value held when enable was cleared.
// - A divisor write while disabled loads the down counter at once.
// - While disabled the down counter holds and does not count.
// - The vector is given on interrupt acknowledge and is readable and writable.
// - With status-modifies-vector off the programmed vector is returned unchanged.
// - With the option on in either channel bits 2..0 carry the pending source code.
// - With the option on and nothing pending bits 2..0 read as 011.
// - A divisor written while running takes effect at the next reload.
// - Reset clears both divisor and generator control registers to zero.

module bcv_clock_vector (
	input  wire logic        clk_in,
	input  wire logic        srst_in,
	input  wire logic        ce_in,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr_in,
	input  wire logic        s_axi_awvalid_in,
	output logic             s_axi_awready_out,
	input  wire logic [31:0] s_axi_wdata_in,
	input  wire logic [3:0]  s_axi_wstrb_in,
	input  wire logic        s_axi_wvalid_in,
	output logic             s_axi_wready_out,
	output logic [1:0]       s_axi_bresp_out,
	output logic             s_axi_bvalid_out,
	input  wire logic        s_axi_bready_in,
	input  wire logic [7:0]  s_axi_araddr_in,
	input  wire logic        s_axi_arvalid_in,
	output logic             s_axi_arready_out,
	output logic [31:0]      s_axi_rdata_out,
	output logic [1:0]       s_axi_rresp_out,
	output logic             s_axi_rvalid_out,
	input  wire logic        s_axi_rready_in,
	// Clock pins, index 0 channel A, index 1 channel B
	input  wire logic [1:0]  receive_clock_pin_in,
	output logic [1:0]       receive_clock_pin_out,
	output logic [1:0]       receive_clock_pin_oe_out,
	input  wire logic [1:0]  transmit_clock_pin_in,
	output logic [1:0]       transmit_clock_pin_out,
	output logic [1:0]       transmit_clock_pin_oe_out,
	output logic [1:0]       rx_engine_clk_out,
	output logic [1:0]       tx_engine_clk_out,
	// Interrupt acknowledge
	input  wire logic        int_pending_in,
	input  wire logic [2:0]  int_source_code_in,
	input  wire logic        int_ack_in,
	output logic [7:0]       int_vector_out,
	output logic             int_vector_valid_out
);

	// ********************************************************************
	// Register state
	// ********************************************************************
	logic [7:0] divisor_value_register_ff [bcv_pkg::NUM_CHAN];
	logic [3:0] baud_gen_control_ff [bcv_pkg::NUM_CHAN];
	logic [7:0] interrupt_vector_ff;
	logic [3:0] int_config_ff;
	logic [1:0] divisor_load_ff;

	logic [1:0] brg_clk;
	logic [7:0] brg_count [bcv_pkg::NUM_CHAN];

	// ********************************************************************
	// AXI state
	// ********************************************************************
	logic        aw_held_ff;
	logic [7:0]  awaddr_ff;
	logic        w_held_ff;
	logic [7:0]  wdata_ff;
	logic        wstrb0_ff;
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0]  rresp_ff;
	logic [7:0]  vector_out_ff;
	logic        vector_valid_ff;

	logic        aw_take;
	logic        w_take;
	logic        ar_take;
	logic        do_write;
	logic        wr_mapped;
	logic        sav_any;
	logic [31:0] nxt_rdata;
	logic [1:0]  nxt_rresp;

	// Vector as presented to the processor on read or acknowledge
	function automatic logic [7:0] presented_vector(
		input logic [7:0] vec,
		input logic       sav,
		input logic       pending,
		input logic [2:0] code
	);
		logic [7:0] result;
		result = vec;
		if (sav) begin
			result[2:0] = pending ? code : bcv_pkg::NO_PENDING_CODE;
		end
		return result;
	endfunction

	assign sav_any = int_config_ff[bcv_pkg::CFG_SAV_A] || int_config_ff[bcv_pkg::CFG_SAV_B];

	// ********************************************************************
	// Write channel handshake
	// ********************************************************************
	// Address and data are parked independently so either may come first
	assign s_axi_awready_out = ce_in && !aw_held_ff && !bvalid_ff;
	assign s_axi_wready_out  = ce_in && !w_held_ff && !bvalid_ff;
	assign aw_take           = s_axi_awvalid_in && s_axi_awready_out;
	assign w_take            = s_axi_wvalid_in && s_axi_wready_out;
	assign do_write          = ce_in && aw_held_ff && w_held_ff;

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			aw_held_ff <= 1'b0;
			awaddr_ff  <= 8'h00;
		end else if (ce_in) begin
			if (aw_take) begin
				aw_held_ff <= 1'b1;
				awaddr_ff  <= s_axi_awaddr_in;
			end else if (do_write) begin
				aw_held_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			w_held_ff <= 1'b0;
			wdata_ff  <= 8'h00;
			wstrb0_ff <= 1'b0;
		end else if (ce_in) begin
			if (w_take) begin
				w_held_ff <= 1'b1;
				wdata_ff  <= s_axi_wdata_in[7:0];
				wstrb0_ff <= s_axi_wstrb_in[0];
			end else if (do_write) begin
				w_held_ff <= 1'b0;
			end
		end
	end

	always_comb begin
		if (awaddr_ff == bcv_pkg::OFF_DIVISOR_A || awaddr_ff == bcv_pkg::OFF_DIVISOR_B) begin
			wr_mapped = 1'b1;
		end else if (awaddr_ff == bcv_pkg::OFF_CONTROL_A || awaddr_ff == bcv_pkg::OFF_CONTROL_B) begin
			wr_mapped = 1'b1;
		end else if (awaddr_ff == bcv_pkg::OFF_VECTOR || awaddr_ff == bcv_pkg::OFF_INT_CONFIG) begin
			wr_mapped = 1'b1;
		end else if (awaddr_ff == bcv_pkg::OFF_GEN_STAT_A || awaddr_ff == bcv_pkg::OFF_GEN_STAT_B) begin
			// Status words are read-only; writes are dropped without error
			wr_mapped = 1'b1;
		end else begin
			wr_mapped = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= bcv_pkg::RESP_OKAY;
		end else if (ce_in) begin
			if (do_write) begin
				bvalid_ff <= 1'b1;
				bresp_ff  <= wr_mapped ? bcv_pkg::RESP_OKAY : bcv_pkg::RESP_SLVERR;
			end else if (s_axi_bready_in) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	// ********************************************************************
	// Register writes
	// ********************************************************************
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			for (int ch = 0; ch < bcv_pkg::NUM_CHAN; ch++) begin
				divisor_value_register_ff[ch] <= bcv_pkg::RST_DIVISOR;
				baud_gen_control_ff[ch]       <= bcv_pkg::RST_CONTROL;
			end
		end else if (ce_in && do_write && wstrb0_ff) begin
			if (awaddr_ff == bcv_pkg::OFF_DIVISOR_A) begin
				divisor_value_register_ff[0] <= wdata_ff;
			end else if (awaddr_ff == bcv_pkg::OFF_DIVISOR_B) begin
				divisor_value_register_ff[1] <= wdata_ff;
			end else if (awaddr_ff == bcv_pkg::OFF_CONTROL_A) begin
				baud_gen_control_ff[0] <= wdata_ff[bcv_pkg::CTL_USED_W-1:0];
			end else if (awaddr_ff == bcv_pkg::OFF_CONTROL_B) begin
				baud_gen_control_ff[1] <= wdata_ff[bcv_pkg::CTL_USED_W-1:0];
			end
		end
	end

	// Load strobe reaches the generator one cycle later, after the
	// divisor register holds the new value
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			divisor_load_ff <= 2'h0;
		end else if (ce_in) begin
			divisor_load_ff[0] <= do_write && wstrb0_ff && awaddr_ff == bcv_pkg::OFF_DIVISOR_A;
			divisor_load_ff[1] <= do_write && wstrb0_ff && awaddr_ff == bcv_pkg::OFF_DIVISOR_B;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			interrupt_vector_ff <= bcv_pkg::RST_VECTOR;
			int_config_ff       <= bcv_pkg::RST_CONFIG;
		end else if (ce_in && do_write && wstrb0_ff) begin
			if (awaddr_ff == bcv_pkg::OFF_VECTOR) begin
				interrupt_vector_ff <= wdata_ff;
			end else if (awaddr_ff == bcv_pkg::OFF_INT_CONFIG) begin
				int_config_ff <= wdata_ff[bcv_pkg::CFG_USED_W-1:0];
			end
		end
	end

	// ********************************************************************
	// Read channel
	// ********************************************************************
	assign s_axi_arready_out = ce_in && !rvalid_ff;
	assign ar_take           = s_axi_arvalid_in && s_axi_arready_out;

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		nxt_rresp = bcv_pkg::RESP_OKAY;
		if (s_axi_araddr_in == bcv_pkg::OFF_DIVISOR_A) begin
			nxt_rdata[7:0] = divisor_value_register_ff[0];
		end else if (s_axi_araddr_in == bcv_pkg::OFF_DIVISOR_B) begin
			nxt_rdata[7:0] = divisor_value_register_ff[1];
		end else if (s_axi_araddr_in == bcv_pkg::OFF_CONTROL_A) begin
			nxt_rdata[3:0] = baud_gen_control_ff[0];
		end else if (s_axi_araddr_in == bcv_pkg::OFF_CONTROL_B) begin
			nxt_rdata[3:0] = baud_gen_control_ff[1];
		end else if (s_axi_araddr_in == bcv_pkg::OFF_VECTOR) begin
			nxt_rdata[7:0] = presented_vector(interrupt_vector_ff, sav_any,
				int_pending_in, int_source_code_in);
		end else if (s_axi_araddr_in == bcv_pkg::OFF_INT_CONFIG) begin
			nxt_rdata[3:0] = int_config_ff;
		end else if (s_axi_araddr_in == bcv_pkg::OFF_GEN_STAT_A) begin
			nxt_rdata[7:0]                  = brg_count[0];
			nxt_rdata[bcv_pkg::STAT_CLK_BIT] = brg_clk[0];
		end else if (s_axi_araddr_in == bcv_pkg::OFF_GEN_STAT_B) begin
			nxt_rdata[7:0]                  = brg_count[1];
			nxt_rdata[bcv_pkg::STAT_CLK_BIT] = brg_clk[1];
		end else begin
			nxt_rresp = bcv_pkg::RESP_SLVERR;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0000_0000;
			rresp_ff  <= bcv_pkg::RESP_OKAY;
		end else if (ce_in) begin
			if (ar_take) begin
				rvalid_ff <= 1'b1;
				rdata_ff  <= nxt_rdata;
				rresp_ff  <= nxt_rresp;
			end else if (s_axi_rready_in) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

	// ********************************************************************
	// Interrupt acknowledge
	// ********************************************************************
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			vector_out_ff   <= 8'h00;
			vector_valid_ff <= 1'b0;
		end else if (ce_in) begin
			vector_valid_ff <= int_ack_in;
			if (int_ack_in) begin
				vector_out_ff <= presented_vector(interrupt_vector_ff, sav_any,
					int_pending_in, int_source_code_in);
			end
		end
	end

	// ********************************************************************
	// Generators and clock routing
	// ********************************************************************
	for (genvar ch = 0; ch < bcv_pkg::NUM_CHAN; ch++) begin : g_chan
		logic rx_pin_level;
		logic tx_pin_level;

		bcv_baud_gen u_gen (
			.clk_in      (clk_in),
			.srst_in     (srst_in),
			.ce_in       (ce_in),
			.enable_in   (baud_gen_control_ff[ch][bcv_pkg::CTL_GEN_ENABLE]),
			.div64_in    (baud_gen_control_ff[ch][bcv_pkg::CTL_DIV64]),
			.divisor_in  (divisor_value_register_ff[ch]),
			.load_in     (divisor_load_ff[ch]),
			.brg_clk_out (brg_clk[ch]),
			.count_out   (brg_count[ch])
		);

		assign receive_clock_pin_out[ch]     = brg_clk[ch];
		assign receive_clock_pin_oe_out[ch]  = baud_gen_control_ff[ch][bcv_pkg::CTL_RX_DRIVE];
		assign transmit_clock_pin_out[ch]    = brg_clk[ch];
		assign transmit_clock_pin_oe_out[ch] = baud_gen_control_ff[ch][bcv_pkg::CTL_TX_DRIVE];

		// Driven pin carries the generator; undriven pin needs an outside clock
		assign rx_pin_level = receive_clock_pin_oe_out[ch] ? brg_clk[ch] : receive_clock_pin_in[ch];
		assign tx_pin_level = transmit_clock_pin_oe_out[ch] ? brg_clk[ch] : transmit_clock_pin_in[ch];

		assign tx_engine_clk_out[ch] = tx_pin_level;
		assign rx_engine_clk_out[ch] = int_config_ff[bcv_pkg::CFG_LOOP_A + ch] ? tx_pin_level
			: rx_pin_level;
	end

	assign s_axi_bvalid_out     = bvalid_ff;
	assign s_axi_bresp_out      = bresp_ff;
	assign s_axi_rvalid_out     = rvalid_ff;
	assign s_axi_rdata_out      = rdata_ff;
	assign s_axi_rresp_out      = rresp_ff;
	assign int_vector_out       = vector_out_ff;
	assign int_vector_valid_out = vector_valid_ff;

endmodule // bcv_clock_vector

// [verif/baud_clock_control_and_vector_bench.sv]
`timescale 1ns/1ps

module baud_clock_control_and_vector_bench;
	// ********************************************************************
	// Signals
	// ********************************************************************
	logic        clk_in = 1'b0;
	logic        srst_in = 1'b1;
	logic        ce = 1'b1;
	logic [7:0]  awa = 8'h00;
	logic [7:0]  ara = 8'h00;
	logic [31:0] wd = 32'h0;
	logic        awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	logic        pend = 1'b0, ack = 1'b0;
	logic [2:0]  code = 3'h0;
	logic        awr, wr, bv, arr, rv, ivv;
	logic [1:0]  bresp, rresp, rxo, rxoe, txo, txoe, rxe, txe, rxw, txw;
	logic [31:0] rd;
	logic [7:0]  iv;
	logic        prv = 1'b0;
	int          n_fail = 0;
	int          comparisons = 0;
	wire         rise = txo[0] & ~prv;

	initial forever #2.5 clk_in = ~clk_in;
	always @(posedge clk_in) prv <= txo[0];

	bcv_clock_vector uut (.clk_in(clk_in), .srst_in(srst_in), .ce_in(ce),
		.s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
		.s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv),
		.s_axi_wready_out(wr), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
		.s_axi_bready_in(br), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
		.s_axi_arready_out(arr), .s_axi_rdata_out(rd), .s_axi_rresp_out(rresp),
		.s_axi_rvalid_out(rv), .s_axi_rready_in(rr), .receive_clock_pin_in(rxw),
		.receive_clock_pin_out(rxo), .receive_clock_pin_oe_out(rxoe),
		.transmit_clock_pin_in(txw), .transmit_clock_pin_out(txo),
		.transmit_clock_pin_oe_out(txoe), .rx_engine_clk_out(rxe), .tx_engine_clk_out(txe),
		.int_pending_in(pend), .int_source_code_in(code), .int_ack_in(ack),
		.int_vector_out(iv), .int_vector_valid_out(ivv));
	bcv_clk_source #(.HALF_NS(7)) u_rxsrc (.oe_in(rxoe), .dev_in(rxo), .wire_out(rxw));
	bcv_clk_source #(.HALF_NS(11)) u_txsrc (.oe_in(txoe), .dev_in(txo), .wire_out(txw));

	// ********************************************************************
	// Tasks
	// ********************************************************************
	task automatic summarize();
		if (n_fail == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Answer flag by number: 0 write response, 1 read address ready, 2 read data
	function automatic logic got(input int w);
		return (w == 0) ? bv : ((w == 1) ? arr : rv);
	endfunction

	task automatic hold(input int w);
		int t = 0;
		while (!got(w) && t < 50) begin
			@(posedge clk_in);
			t++;
		end
		if (!got(w))
			chk("handshake", 32'h1, 32'h0);
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] er = bcv_pkg::RESP_OKAY);
		logic ad = 1'b0;
		logic dd = 1'b0;
		int t = 0;
		@(posedge clk_in);
		awa <= a;
		awv <= 1'b1;
		wd <= d;
		wv <= 1'b1;
		while (!(ad && dd) && t < 50) begin
			@(posedge clk_in);
			t++;
			if (awr && !ad) begin
				ad = 1'b1;
				awv <= 1'b0;
			end
			if (wr && !dd) begin
				dd = 1'b1;
				wv <= 1'b0;
			end
		end
		@(posedge clk_in);
		hold(0);
		// Late ready keeps the response waiting a cycle
		br <= 1'b1;
		@(posedge clk_in);
		br <= 1'b0;
		chk("bresp", 32'(er), 32'(bresp));
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d,
			input logic [1:0] er = bcv_pkg::RESP_OKAY);
		@(posedge clk_in);
		ara <= a;
		arv <= 1'b1;
		@(posedge clk_in);
		hold(1);
		arv <= 1'b0;
		@(posedge clk_in);
		hold(2);
		rr <= 1'b1;
		@(posedge clk_in);
		rr <= 1'b0;
		d = rd;
		chk("rresp", 32'(er), 32'(rresp));
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		axr(a, d);
		chk($sformatf("register %h", a), e, d);
	endtask

	task automatic per(input int e);
		int n = 0;
		do @(posedge clk_in); while (!rise && n++ < 300);
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (!rise && n < 300);
		chk("period", 32'(e), 32'(n));
	endtask

	task automatic lp(input logic m);
		repeat (40) begin
			@(posedge clk_in);
			#1;
			chk("rx engine clock", 32'(m ? txw : rxw), 32'(rxe));
			chk("tx engine clock", 32'(txw), 32'(txe));
		end
	endtask

	task automatic ackc(input logic p, input logic [2:0] c, input logic [7:0] e);
		@(posedge clk_in);
		ack <= 1'b1;
		pend <= p;
		code <= c;
		@(posedge clk_in);
		ack <= 1'b0;
		#1;
		chk("vector valid", 32'h1, 32'(ivv));
		chk("vector", 32'(e), 32'(iv));
	endtask

	// ********************************************************************
	// Sequence
	// ********************************************************************
	initial begin
		#50000;
		n_fail++;
		summarize();
	end

	initial begin
		logic [31:0] d, c1, c2;
		repeat (4) @(posedge clk_in);
		srst_in <= 1'b0;
		rdc(bcv_pkg::OFF_DIVISOR_A, 32'h0);
		rdc(bcv_pkg::OFF_CONTROL_B, 32'h0);
		axw(bcv_pkg::OFF_CONTROL_B, 32'hF2);
		rdc(bcv_pkg::OFF_CONTROL_B, 32'h02);
		axw(bcv_pkg::OFF_DIVISOR_B, 32'h5A);
		rdc(bcv_pkg::OFF_GEN_STAT_B, 32'h5A);
		rdc(bcv_pkg::OFF_VECTOR, 32'(bcv_pkg::RST_VECTOR));
		axr(8'h20, d, bcv_pkg::RESP_SLVERR);
		axw(8'h20, 32'h1, bcv_pkg::RESP_SLVERR);
		axw(bcv_pkg::OFF_CONTROL_A, 32'hFF);
		rdc(bcv_pkg::OFF_CONTROL_A, 32'h0F);
		axw(bcv_pkg::OFF_CONTROL_A, 32'h0C);
		axw(bcv_pkg::OFF_DIVISOR_A, 32'hC8);
		axr(bcv_pkg::OFF_GEN_STAT_A, d);
		chk("loaded count", 32'hC8, 32'(d[7:0]));
		repeat (20) @(posedge clk_in);
		axr(bcv_pkg::OFF_GEN_STAT_A, d);
		chk("idle count", 32'hC8, 32'(d[7:0]));
		axw(bcv_pkg::OFF_CONTROL_A, 32'h0D);
		repeat (40) @(posedge clk_in);
		axw(bcv_pkg::OFF_CONTROL_A, 32'h0C);
		axr(bcv_pkg::OFF_GEN_STAT_A, c1);
		repeat (20) @(posedge clk_in);
		rdc(bcv_pkg::OFF_GEN_STAT_A, c1);
		axw(bcv_pkg::OFF_CONTROL_A, 32'h0D);
		repeat (40) @(posedge clk_in);
		// Clock enable low must freeze the running counter
		ce <= 1'b0;
		repeat (40) @(posedge clk_in);
		ce <= 1'b1;
		axw(bcv_pkg::OFF_CONTROL_A, 32'h0C);
		axr(bcv_pkg::OFF_GEN_STAT_A, c2);
		chk("resumed count", 32'h1, 32'(int'(c2[7:0]) + 10 <= int'(c1[7:0])));
		chk("frozen count", 32'h1, 32'(int'(c2[7:0]) + 30 >= int'(c1[7:0])));
		axw(bcv_pkg::OFF_DIVISOR_A, 32'h1);
		axw(bcv_pkg::OFF_CONTROL_A, 32'h0D);
		#1;
		chk("pin drive", 32'h3, 32'({rxoe[0], txoe[0]}));
		chk("rx from generator", 32'(rxo[0]), 32'(rxe[0]));
		per(bcv_pkg::MIN_RATIO_DIV4);
		axw(bcv_pkg::OFF_DIVISOR_A, 32'h3);
		repeat (30) @(posedge clk_in);
		per(3 * bcv_pkg::MIN_RATIO_DIV4);
		axw(bcv_pkg::OFF_CONTROL_A, 32'h0C);
		axw(bcv_pkg::OFF_DIVISOR_A, 32'h1);
		axw(bcv_pkg::OFF_CONTROL_A, 32'h0F);
		per(bcv_pkg::MIN_RATIO_DIV64);
		@(posedge clk_in);
		srst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		srst_in <= 1'b0;
		rdc(bcv_pkg::OFF_DIVISOR_A, 32'h0);
		rdc(bcv_pkg::OFF_CONTROL_A, 32'h0);
		lp(1'b0);
		axw(bcv_pkg::OFF_INT_CONFIG, 32'hC);
		lp(1'b1);
		axw(bcv_pkg::OFF_INT_CONFIG, 32'h0);
		axw(bcv_pkg::OFF_VECTOR, 32'hA8);
		ackc(1'b1, 3'h5, 8'hA8);
		rdc(bcv_pkg::OFF_VECTOR, 32'hA8);
		axw(bcv_pkg::OFF_INT_CONFIG, 32'h1);
		ackc(1'b0, 3'h5, 8'hA8 | 8'(bcv_pkg::NO_PENDING_CODE));
		ackc(1'b1, 3'h5, 8'hAD);
		axw(bcv_pkg::OFF_INT_CONFIG, 32'h2);
		ackc(1'b1, 3'h6, 8'hAE);
		rdc(bcv_pkg::OFF_VECTOR, 32'hAE);
		summarize();
	end
endmodule // baud_clock_control_and_vector_bench

// [verif/bcv_clk_source.sv]
`timescale 1ns/1ps

module bcv_clk_source #(
	parameter int HALF_NS = 7
) (
	input  wire logic [1:0] oe_in,
	input  wire logic [1:0] dev_in,
	output logic      [1:0] wire_out
);
	// ********************************************************************
	// Outside baud clock
	// ********************************************************************
	logic ext = 1'b0;

	// Runs free, unrelated in phase to the system clock
	always #(HALF_NS) ext = ~ext;
	assign wire_out = (oe_in & dev_in) | (~oe_in & {2{ext}});
endmodule // bcv_clk_source

// [verif/bcv_clock_vector_asserts.sv]
`timescale 1ns/1ps

module bcv_clock_vector_asserts (
	input wire logic        clk_in,
	input wire logic        srst_in,
	input wire logic        ce_in,
	input wire logic        s_axi_awready_out,
	input wire logic        s_axi_wready_out,
	input wire logic [1:0]  s_axi_bresp_out,
	input wire logic        s_axi_bvalid_out,
	input wire logic        s_axi_bready_in,
	input wire logic        s_axi_arvalid_in,
	input wire logic        s_axi_arready_out,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic        s_axi_rvalid_out,
	input wire logic        s_axi_rready_in,
	input wire logic [1:0]  receive_clock_pin_oe_out,
	input wire logic [1:0]  transmit_clock_pin_in,
	input wire logic [1:0]  transmit_clock_pin_out,
	input wire logic [1:0]  transmit_clock_pin_oe_out,
	input wire logic [1:0]  tx_engine_clk_out,
	input wire logic        int_ack_in,
	input wire logic        int_vector_valid_out
);
	// ********************************************************************
	// Checks
	// ********************************************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);

	read_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
		else $error("read answer missing");
	read_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
		s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data dropped");
	write_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
		s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write response dropped");
	write_block_a: assert property (s_axi_bvalid_out |->
		!s_axi_awready_out && !s_axi_wready_out) else $error("write taken too early");
	ack_answer_a: assert property (int_ack_in && ce_in |=> int_vector_valid_out)
		else $error("vector not given");
	ack_pulse_a: assert property (int_vector_valid_out |-> $past(int_ack_in))
		else $error("vector without acknowledge");
	tx_route_a: assert property (tx_engine_clk_out ==
		((transmit_clock_pin_oe_out & transmit_clock_pin_out)
		| (~transmit_clock_pin_oe_out & transmit_clock_pin_in))) else $error("tx clock source");
	min_half_a: assert property ($changed(transmit_clock_pin_out[0]) |=>
		$stable(transmit_clock_pin_out[0])) else $error("generator faster than minimum");
	reset_clear_a: assert property ($fell(srst_in) |-> transmit_clock_pin_oe_out == 2'h0
		&& receive_clock_pin_oe_out == 2'h0) else $error("pin drive after reset");

	cover property (int_vector_valid_out);
	cover property (s_axi_bvalid_out && !s_axi_bready_in);
	cover property ($rose(transmit_clock_pin_out[0]) && transmit_clock_pin_oe_out[0]);
endmodule // bcv_clock_vector_asserts

bind bcv_clock_vector bcv_clock_vector_asserts u_chk (.*);
